//--- core/tmb_defines.svh
// Constants of the 16-bit timer and event counter: register indices,
// field positions, reset values and prescaler taps.
// Assumes inclusion by its bare name from the package and the core module.
`ifndef TMB_DEFINES_SVH
`define TMB_DEFINES_SVH

// Bus shape and answers.
`define TMB_AXI_AW        16
`define TMB_IDX_W         14
`define TMB_RESP_OKAY     2'h0
`define TMB_RESP_SLVERR   2'h2

// Register indices; the byte address is four times the index.
`define TMB_IDX_RUN       14'h1190
`define TMB_IDX_IRQ_EN    14'h1191
`define TMB_IDX_MODE      14'h1192
`define TMB_IDX_FFCR      14'h1193
`define TMB_IDX_CMP0_LO   14'h1198
`define TMB_IDX_CMP0_HI   14'h1199
`define TMB_IDX_CMP1_LO   14'h119A
`define TMB_IDX_CMP1_HI   14'h119B
`define TMB_IDX_CAP0_LO   14'h119C
`define TMB_IDX_CAP0_HI   14'h119D
`define TMB_IDX_CAP1_LO   14'h119E
`define TMB_IDX_CAP1_HI   14'h119F

// Run control fields.
`define TMB_RUN_BIT       0
`define TMB_PRUN_BIT      2

// Mode fields.
`define TMB_MOD_CLK_LSB   0
`define TMB_MOD_CLE_BIT   2
`define TMB_MOD_CPM_LSB   3
`define TMB_MOD_SWCAP_BIT 5

// Flip-flop control fields: command in 1:0, trigger enables in 5:2.
`define TMB_FF_CMD_LSB    0
`define TMB_FF_EN_LSB     2
`define TMB_FF_CMD_INV    2'h0
`define TMB_FF_CMD_SET    2'h1
`define TMB_FF_CMD_CLR    2'h2

// Interrupt enable fields: a level of zero disables the source.
`define TMB_IRQ0_LVL_LSB  0
`define TMB_IRQ1_LVL_LSB  4

// Reset values.
`define TMB_RST_RUN       8'h00
`define TMB_RST_MODE      8'h20
`define TMB_RST_IRQ_EN    8'h00
`define TMB_RST_FF_EN     4'h0

// Prescaler width and tap bits for clock selects 01, 10 and 11.
`define TMB_PS_WIDTH      8
`define TMB_PS_TAP1       1
`define TMB_PS_TAP2       3
`define TMB_PS_TAP3       5

`endif

//--- core/tmb_pkg.sv
// Types of the 16-bit timer and event counter: bus carriers and state.
// Assumes the defines header sits beside it on the include path.
`include "tmb_defines.svh"

package tmb_pkg;

  // Requests from the AXI4-Lite master.
  typedef struct packed {
    logic                     awvalid;
    logic [`TMB_AXI_AW-1:0]   awaddr;
    logic                     wvalid;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bready;
    logic                     arvalid;
    logic [`TMB_AXI_AW-1:0]   araddr;
    logic                     rready;
  } tmb_axi_req_s;

  // Answers to the AXI4-Lite master.
  typedef struct packed {
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } tmb_axi_rsp_s;

  // Whole state of the timer channel.
  typedef struct packed {
    tmb_axi_rsp_s             rsp;
    logic                     aw_held;
    logic [`TMB_IDX_W-1:0]    aw_idx;
    logic                     w_held;
    logic [7:0]               w_byte;
    logic                     w_lane;
    logic [7:0]               run;
    logic [7:0]               mode;
    logic [3:0]               ff_en;
    logic                     ff;
    logic [7:0]               irq_en;
    logic [15:0]              cmp0;
    logic [15:0]              cmp1;
    logic [15:0]              cap0;
    logic [15:0]              cap1;
    logic [15:0]              cnt;
    logic [`TMB_PS_WIDTH-1:0] ps;
    logic                     ext_prev;
    logic                     irq0;
    logic                     irq1;
  } tmb_state_s;

endpackage

//--- core/tmb_timer16.sv
// 16-bit up-counter timer channel with two compares, two captures,
// a prescaler, an external count input and an AXI4-Lite register slave.
// Assumes one 10 MHz clock, a synchronous active-low reset and an
// external count input already synchronous to that clock.
//
// What this block does
// - In interval mode the compare-1 match interrupt fires each time the counter reaches compare 1.
// - The interrupt enable register sets a level per source, and level zero keeps a source off.
// - Clock-select codes 01, 10 and 11 pick a prescaler tap, and capture mode 00 disables the pin captures.
// - A flip-flop control value with trigger enables clear stops every match toggle of the output.
// - Clock-select code 00 makes the external count input the counter clock.
// - In that mode the counter steps by one on each rising edge of the input and ignores falls.
// - A software capture copies the running count to capture 0 without stopping the counter.
// - In event mode the compare-1 match interrupt fires when the count reaches compare 1.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`include "tmb_defines.svh"

module tmb_timer16 #(
  parameter int PS_W    = `TMB_PS_WIDTH,
  parameter int PS_TAP1 = `TMB_PS_TAP1,
  parameter int PS_TAP2 = `TMB_PS_TAP2,
  parameter int PS_TAP3 = `TMB_PS_TAP3
) (
  input  wire logic                  core_clk_i,             // Core clock, 10 MHz.
  input  wire logic                  rst_n_i,                // Synchronous reset, low.
  input  wire tmb_pkg::tmb_axi_req_s axi_i,                  // AXI4-Lite requests.
  output tmb_pkg::tmb_axi_rsp_s      axi_o,                  // AXI4-Lite answers.
  input  wire logic                  external_count_input_i, // Event and capture input.
  output logic                       timer_ff_o,             // Timer flip-flop output.
  output logic                       compare0_match_irq_o,   // Compare-0 match pulse.
  output logic                       compare1_match_irq_o,   // Compare-1 match pulse.
  output logic [2:0]                 compare1_irq_level_o    // Compare-1 priority level.
);
  import tmb_pkg::*;

  // The state struct fixes the prescaler width, so the parameter must match it,
  // and the taps must lie inside the prescaler counter.
  if (PS_W != `TMB_PS_WIDTH || PS_TAP1 >= PS_TAP2 || PS_TAP2 >= PS_TAP3 || PS_TAP3 >= PS_W)
  begin : g_bad_taps
    $error("Prescaler width must match the state and taps must rise below it.");
  end

  localparam logic [PS_W-1:0] MASK1 = PS_W'((32'h1 << (PS_TAP1 + 1)) - 32'h1);
  localparam logic [PS_W-1:0] MASK2 = PS_W'((32'h1 << (PS_TAP2 + 1)) - 32'h1);
  localparam logic [PS_W-1:0] MASK3 = PS_W'((32'h1 << (PS_TAP3 + 1)) - 32'h1);

  tmb_state_s s;
  tmb_state_s next_s;

  logic        running;
  logic        ext_rise;
  logic        ext_fall;
  logic        tick;
  logic [15:0] cnt_inc;
  logic        hit0;
  logic        hit1;
  logic        wr_do;
  logic [8:0]  rd_word;
  logic [8:0]  wr_word;

  // Read mux: bit 8 tells whether the index is mapped at all.
  function automatic logic [8:0] rd_reg(input tmb_state_s st,
                                        input logic [`TMB_IDX_W-1:0] idx);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    case (idx)
      `TMB_IDX_RUN:     r[7:0] = st.run;
      `TMB_IDX_IRQ_EN:  r[7:0] = st.irq_en;
      `TMB_IDX_MODE:    r[7:0] = st.mode;
      `TMB_IDX_FFCR:    r[7:0] = {2'h3, st.ff_en, 2'h3};
      `TMB_IDX_CMP0_LO: r[7:0] = 8'h00;
      `TMB_IDX_CMP0_HI: r[7:0] = 8'h00;
      `TMB_IDX_CMP1_LO: r[7:0] = 8'h00;
      `TMB_IDX_CMP1_HI: r[7:0] = 8'h00;
      `TMB_IDX_CAP0_LO: r[7:0] = st.cap0[7:0];
      `TMB_IDX_CAP0_HI: r[7:0] = st.cap0[15:8];
      `TMB_IDX_CAP1_LO: r[7:0] = st.cap1[7:0];
      `TMB_IDX_CAP1_HI: r[7:0] = st.cap1[15:8];
      default:          r = 9'h000;
    endcase
    return r;
  endfunction

  // Event decode shared by the counter, captures and assertions.
  always_comb
  begin
    running  = s.run[`TMB_RUN_BIT] && s.run[`TMB_PRUN_BIT];
    ext_rise = external_count_input_i && !s.ext_prev;
    ext_fall = !external_count_input_i && s.ext_prev;
    case (s.mode[`TMB_MOD_CLK_LSB +: 2])
      2'h0:    tick = ext_rise; // External clock
      2'h1:    tick = s.run[`TMB_PRUN_BIT] && ((s.ps & MASK1) == MASK1);
      2'h2:    tick = s.run[`TMB_PRUN_BIT] && ((s.ps & MASK2) == MASK2);
      2'h3:    tick = s.run[`TMB_PRUN_BIT] && ((s.ps & MASK3) == MASK3);
      default: tick = 1'b0;
    endcase
    cnt_inc = s.cnt + 16'h0001;
    hit0    = running && tick && (cnt_inc == s.cmp0);
    hit1    = running && tick && (cnt_inc == s.cmp1);
    wr_do   = s.aw_held && s.w_held && !s.rsp.bvalid;
    rd_word = rd_reg(s, axi_i.araddr[`TMB_AXI_AW-1:2]);
    wr_word = rd_reg(s, s.aw_idx); // Only bit 8 is used, to answer the write.
  end

  // Next state: counter, interrupts, captures, flip-flop, then the bus.
  // Bus writes are applied last so a set, clear or invert command wins over a toggle; command 11 keeps it.
  always_comb
  begin
    next_s          = s;
    next_s.ext_prev = external_count_input_i;
    next_s.irq0     = 1'b0;
    next_s.irq1     = 1'b0;
    next_s.ps       = s.run[`TMB_PRUN_BIT] ? s.ps + PS_W'(1) : '0;

    if (!s.run[`TMB_RUN_BIT])
      next_s.cnt = 16'h0000;
    else if (running && tick)
      next_s.cnt = (s.mode[`TMB_MOD_CLE_BIT] && s.cnt == s.cmp1) ? 16'h0000 : cnt_inc;

    next_s.irq1 = hit1 && (s.irq_en[`TMB_IRQ1_LVL_LSB +: 3] != 3'h0);
    next_s.irq0 = hit0 && (s.irq_en[`TMB_IRQ0_LVL_LSB +: 3] != 3'h0);

    // Capture mode 00 disables the pin captures.
    if (s.mode[`TMB_MOD_CPM_LSB +: 2] != 2'h0)
    begin
      if (ext_rise)
        next_s.cap0 = s.cnt;
      if (ext_fall)
        next_s.cap1 = s.cnt;
    end

    if ((s.ff_en[0] && hit0) || (s.ff_en[1] && hit1) ||
        (s.ff_en[2] && ext_rise && s.mode[`TMB_MOD_CPM_LSB +: 2] != 2'h0) ||
        (s.ff_en[3] && ext_fall && s.mode[`TMB_MOD_CPM_LSB +: 2] != 2'h0))
      next_s.ff = !s.ff;

    // Write address and data are taken in either order and held.
    if (axi_i.awvalid && s.rsp.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx  = axi_i.awaddr[`TMB_AXI_AW-1:2];
    end
    if (axi_i.wvalid && s.rsp.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.w_byte = axi_i.wdata[7:0];
      next_s.w_lane = axi_i.wstrb[0];
    end

    // Perform the write once both halves are held.
    if (wr_do)
    begin
      next_s.aw_held    = 1'b0;
      next_s.w_held     = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = wr_word[8] ? `TMB_RESP_OKAY : `TMB_RESP_SLVERR;
      if (s.w_lane)
      begin
        case (s.aw_idx)
          `TMB_IDX_RUN:    next_s.run = s.w_byte;
          `TMB_IDX_IRQ_EN: next_s.irq_en = s.w_byte; // Levels
          `TMB_IDX_MODE:
          begin
            next_s.mode = s.w_byte;
            next_s.mode[`TMB_MOD_SWCAP_BIT] = 1'b1;
            if (!s.w_byte[`TMB_MOD_SWCAP_BIT])
              next_s.cap0 = s.cnt;
          end
          `TMB_IDX_FFCR:
          begin
            next_s.ff_en = s.w_byte[`TMB_FF_EN_LSB +: 4];
            case (s.w_byte[`TMB_FF_CMD_LSB +: 2])
              `TMB_FF_CMD_INV: next_s.ff = !s.ff;
              `TMB_FF_CMD_SET: next_s.ff = 1'b1;
              `TMB_FF_CMD_CLR: next_s.ff = 1'b0;
              default:         next_s.ff = next_s.ff;
            endcase
          end
          `TMB_IDX_CMP0_LO: next_s.cmp0[7:0]  = s.w_byte;
          `TMB_IDX_CMP0_HI: next_s.cmp0[15:8] = s.w_byte;
          `TMB_IDX_CMP1_LO: next_s.cmp1[7:0]  = s.w_byte;
          `TMB_IDX_CMP1_HI: next_s.cmp1[15:8] = s.w_byte;
          default:          next_s.run = s.run;
        endcase
      end
    end
    if (s.rsp.bvalid && axi_i.bready)
      next_s.rsp.bvalid = 1'b0;

    // Read: one outstanding, data captured at the address handshake.
    if (axi_i.arvalid && s.rsp.arready)
    begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata  = {24'h000000, rd_word[7:0]};
      next_s.rsp.rresp  = rd_word[8] ? `TMB_RESP_OKAY : `TMB_RESP_SLVERR;
    end
    else if (s.rsp.rvalid && axi_i.rready)
      next_s.rsp.rvalid = 1'b0;

    // Ready flags are registered, so each output comes from a flip-flop.
    next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.w_held && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s        <= '0;
      s.run    <= `TMB_RST_RUN;
      s.mode   <= `TMB_RST_MODE;
      s.irq_en <= `TMB_RST_IRQ_EN;
      s.ff_en  <= `TMB_RST_FF_EN;
    end
    else
      s <= next_s;
  end

  // Outputs straight from the state flip-flops.
  assign axi_o                = s.rsp;
  assign timer_ff_o           = s.ff;
  assign compare0_match_irq_o = s.irq0;
  assign compare1_match_irq_o = s.irq1;
  assign compare1_irq_level_o = s.irq_en[`TMB_IRQ1_LVL_LSB +: 3];

  // Checks on the counter, captures, flip-flop and interrupts.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_stop_clears: assert property (!s.run[`TMB_RUN_BIT] |=> s.cnt == 16'h0000)
    else $error("Counter not cleared while stopped.");

  a_prun_holds: assert property (
    s.run[`TMB_RUN_BIT] && !s.run[`TMB_PRUN_BIT] |=> s.cnt == $past(s.cnt))
    else $error("Counter moved without prescaler run.");

  a_ext_rise_step: assert property (
    running && s.mode[1:0] == 2'h0 && ext_rise && !(s.mode[2] && s.cnt == s.cmp1)
    |=> s.cnt == $past(cnt_inc))
    else $error("Rising edge did not step the counter.");

  a_ext_fall_hold: assert property (
    running && s.mode[1:0] == 2'h0 && !ext_rise && !wr_do |=> $stable(s.cnt))
    else $error("Counter moved without a rising edge.");

  a_cmp1_irq: assert property (
    hit1 && s.irq_en[6:4] != 3'h0 |=> compare1_match_irq_o ##1 !compare1_match_irq_o)
    else $error("Compare-1 match pulse wrong.");

  a_irq1_cause: assert property (
    compare1_match_irq_o |-> $past(hit1) && $past(s.cnt) + 16'h0001 == $past(s.cmp1))
    else $error("Compare-1 interrupt without a match.");

  a_irq0_masked: assert property (
    s.irq_en[2:0] == 3'h0 && !wr_do |=> !compare0_match_irq_o)
    else $error("Disabled compare-0 interrupt fired.");

  a_sw_capture: assert property (
    wr_do && s.w_lane && s.aw_idx == `TMB_IDX_MODE && !s.w_byte[5]
    |=> s.cap0 == $past(s.cnt) && s.mode[5])
    else $error("Software capture lost the count.");

  a_ff_no_toggle: assert property (
    s.ff_en == 4'h0 && !wr_do |=> $stable(timer_ff_o))
    else $error("Flip-flop toggled with triggers off.");

  a_cmp_bytes: assert property (
    wr_do && s.w_lane && s.aw_idx == `TMB_IDX_CMP1_LO
    |=> s.cmp1[7:0] == $past(s.w_byte) && s.cmp1[15:8] == $past(s.cmp1[15:8]))
    else $error("Compare-1 low byte write wrong.");

  // Prescaler ticks: a tick steps the counter, and no tick leaves it alone.
  a_tick_step: assert property (
    running && s.mode[`TMB_MOD_CLK_LSB +: 2] != 2'h0 && tick &&
    !(s.mode[`TMB_MOD_CLE_BIT] && s.cnt == s.cmp1)
    |=> s.cnt == $past(cnt_inc))
    else $error("Prescaler tick did not step the counter.");

  a_no_tick_hold: assert property (
    running && s.mode[`TMB_MOD_CLK_LSB +: 2] != 2'h0 && !tick |=> $stable(s.cnt))
    else $error("Counter moved between prescaler ticks.");

  // The interval restarts from zero once the count has reached compare 1.
  a_interval_wrap: assert property (
    running && tick && s.mode[`TMB_MOD_CLE_BIT] && s.cnt == s.cmp1 |=> s.cnt == 16'h0000)
    else $error("Counter did not restart after the interval.");

  // Compare-0 pulses only after a match, and only with a nonzero level.
  a_irq0_cause: assert property (
    compare0_match_irq_o
    |-> $past(hit0) && $past(s.irq_en[`TMB_IRQ0_LVL_LSB +: 3]) != 3'h0)
    else $error("Compare-0 interrupt without an enabled match.");

  // Pin captures follow the input edges only while a capture mode is set.
  a_pin_capture: assert property (
    s.mode[`TMB_MOD_CPM_LSB +: 2] != 2'h0 && ext_rise && !wr_do
    |=> s.cap0 == $past(s.cnt))
    else $error("Rising input edge did not load capture 0.");

  a_capture_off: assert property (
    s.mode[`TMB_MOD_CPM_LSB +: 2] == 2'h0 && !wr_do |=> $stable(s.cap0) && $stable(s.cap1))
    else $error("Capture moved with capture mode off.");

  // Flip-flop commands take effect with the write that carries them.
  a_ff_set: assert property (
    wr_do && s.w_lane && s.aw_idx == `TMB_IDX_FFCR &&
    s.w_byte[`TMB_FF_CMD_LSB +: 2] == `TMB_FF_CMD_SET |=> timer_ff_o)
    else $error("Flip-flop set command lost.");

  a_ff_clear: assert property (
    wr_do && s.w_lane && s.aw_idx == `TMB_IDX_FFCR &&
    s.w_byte[`TMB_FF_CMD_LSB +: 2] == `TMB_FF_CMD_CLR |=> !timer_ff_o)
    else $error("Flip-flop clear command lost.");

  a_irq1_masked: assert property (
    s.irq_en[`TMB_IRQ1_LVL_LSB +: 3] == 3'h0 && !wr_do |=> !compare1_match_irq_o)
    else $error("Disabled compare-1 interrupt fired.");

  c_event_match: cover property (s.mode[1:0] == 2'h0 && compare1_match_irq_o);
  c_interval_match: cover property (s.mode[1:0] != 2'h0 && compare1_match_irq_o);
  c_sw_capture: cover property (wr_do && s.aw_idx == `TMB_IDX_MODE && !s.w_byte[5]);
  c_axi_read: cover property (axi_o.rvalid && axi_i.rready);
  c_pin_capture: cover property (s.mode[`TMB_MOD_CPM_LSB +: 2] != 2'h0 && ext_fall);

endmodule

//--- testbench/tmb_event_src.sv
// Model of the far side's external count source driving the event input pin.
// Assumes the bench calls its task from a process already synced to the core clock.
`timescale 1ns/1ns

module tmb_event_src (
  input  wire logic core_clk_i, // Core clock.
  output logic      pin_o       // Event input level.
);

  // The pin idles low between bursts, as a quiet sensor line would.
  initial pin_o = 1'b0;

  // Each pulse can stay high for several cycles, so a count on the fall would show up.
  // rise then fall
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk_i);
      pin_o <= 1'b1;
      repeat (hi) @(posedge core_clk_i);
      pin_o <= 1'b0;
      repeat (lo) @(posedge core_clk_i);
    end
  endtask

endmodule

//--- testbench/tb_timer16_interval_event_counter.sv
// Self-checking bench for the 16-bit timer and event counter channel.
// Assumes the package and defines header of the core are on the include path.
`timescale 1ns/1ns
`include "tmb_defines.svh"

module tb_timer16_interval_event_counter;
  import tmb_pkg::*;

  localparam logic [1:0] OK = `TMB_RESP_OKAY;

  logic         core_clk;
  logic         rst_n;
  tmb_axi_req_s req;
  tmb_axi_rsp_s rsp;
  logic         ev_pin;
  logic         ff;
  logic         irq0;
  logic         irq1;
  logic [2:0]   lvl1;
  logic [7:0]   rd_byte;
  int           err_total = 0;
  int           checks = 0;
  int           n_irq0 = 0;
  int           n_irq1 = 0;
  int           base1;
  int           gap;

  tmb_timer16 DUT (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .axi_i(req), .axi_o(rsp),
    .external_count_input_i(ev_pin), .timer_ff_o(ff), .compare0_match_irq_o(irq0),
    .compare1_match_irq_o(irq1), .compare1_irq_level_o(lvl1)
  );

  tmb_event_src src (
    .core_clk_i(core_clk),
    .pin_o     (ev_pin)
  );

  // The 10 MHz core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Interrupt pulses last one cycle, so they are tallied on every rising edge.
  always @(posedge core_clk)
  begin
    if (irq0 === 1'b1)
      n_irq0++;
    if (irq1 === 1'b1)
      n_irq1++;
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run; the watchdog ends here as well.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One plain register write; the leading edge keeps two drives of a signal apart.
  // plain single writes
  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= {idx, 2'b00};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1 && n < 100);
    req.bready <= 1'b0;
    chk("bresp", {29'h0, rsp.bvalid, rsp.bresp}, {29'h0, 1'b1, er});
  endtask

  // One plain register read returning the low byte.
  task automatic rd(input logic [13:0] idx, input logic [1:0] er, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= {idx, 2'b00};
    req.rready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1 && n < 100);
    req.rready <= 1'b0;
    d = rsp.rdata[7:0];
    chk("rresp", {29'h0, rsp.rvalid, rsp.rresp}, {29'h0, 1'b1, er});
  endtask

  task automatic rdchk(input string what, input logic [13:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    rd(idx, OK, d);
    chk(what, {24'h0, d}, {24'h0, exp});
  endtask

  // Measures the cycles between two compare-1 pulses, skipping the first partial period.
  task automatic irq_gap(output int g);
    int n;
    n = 0;
    while (irq1 !== 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    g = 1;
    while (irq1 !== 1'b1 && g < 2000)
    begin
      @(posedge core_clk);
      g++;
    end
  endtask

  // Software capture then read of the running count.
  task automatic cap_chk(input string what, input logic [7:0] exp);
    wr(`TMB_IDX_MODE, 8'h04, OK);
    rdchk(what, `TMB_IDX_CAP0_LO, exp);
  endtask

  // The longest test needs under 1000 cycles; thirty times that leaves room for slow answers.
  initial
  begin
    #(30000 * 100);
    err_total++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk("mode rst", `TMB_IDX_MODE, 8'h20);
    rdchk("run rst", `TMB_IDX_RUN, 8'h00);
    rdchk("cmp1 lo", `TMB_IDX_CMP1_LO, 8'h00);
    rd(14'h1000, `TMB_RESP_SLVERR, rd_byte);
    chk("unmapped", {24'h0, rd_byte}, 32'h0);
    wr(14'h1000, 8'h00, `TMB_RESP_SLVERR);
    $display("test reset done");
    wr(`TMB_IDX_RUN, 8'h00, OK);
    wr(`TMB_IDX_IRQ_EN, 8'h40, OK);
    chk("level1", {29'h0, lvl1}, 32'h4);
    wr(`TMB_IDX_FFCR, 8'hCD, OK);
    rdchk("ffcr en", `TMB_IDX_FFCR, 8'hCF);
    chk("ff set", {31'h0, ff}, 32'h1);
    wr(`TMB_IDX_FFCR, 8'hC2, OK);
    chk("ff clear", {31'h0, ff}, 32'h0);
    wr(`TMB_IDX_FFCR, 8'hC0, OK);
    chk("ff invert", {31'h0, ff}, 32'h1);
    // Triggers off and no command: the flip-flop must keep its 1 through every match.
    wr(`TMB_IDX_FFCR, 8'hC3, OK);
    rdchk("ffcr", `TMB_IDX_FFCR, 8'hC3);
    // Compare 0 matches every interval, so its disabled level is really put to the test.
    wr(`TMB_IDX_CMP0_LO, 8'h02, OK);
    wr(`TMB_IDX_CMP1_LO, 8'h03, OK);
    wr(`TMB_IDX_CMP1_HI, 8'h00, OK);
    // Period is four ticks of compare 1 plus one, each tick 4, 16 or 64 cycles.
    for (int c = 1; c <= 3; c++)
    begin
      wr(`TMB_IDX_MODE, 8'h24 | 8'(c), OK);
      wr(`TMB_IDX_RUN, 8'h05, OK);
      irq_gap(gap);
      chk("irq gap", gap, 32'(4 << (2 * c)));
    end
    $display("test interval done");
    wr(`TMB_IDX_RUN, 8'h00, OK);
    wr(`TMB_IDX_MODE, 8'h24, OK);
    wr(`TMB_IDX_RUN, 8'h05, OK);
    base1 = n_irq1;
    src.pulses(2, 3, 2);
    cap_chk("cap0 lo", 8'h02);
    rdchk("cap0 hi", `TMB_IDX_CAP0_HI, 8'h00);
    rdchk("mode back", `TMB_IDX_MODE, 8'h24);
    src.pulses(1, 3, 2);
    chk("irq1 count", n_irq1 - base1, 32'h1);
    $display("test event done");
    wr(`TMB_IDX_RUN, 8'h00, OK);
    cap_chk("cap0 stop", 8'h00);
    wr(`TMB_IDX_RUN, 8'h01, OK);
    src.pulses(2, 1, 1);
    cap_chk("cap0 noprun", 8'h00);
    wr(`TMB_IDX_RUN, 8'h05, OK);
    src.pulses(1, 1, 1);
    cap_chk("cap0 run", 8'h01);
    chk("irq0 count", n_irq0, 32'h0);
    // A nonzero level lets compare 0 fire; capture mode 01 loads both captures from the pin.
    wr(`TMB_IDX_IRQ_EN, 8'h41, OK);
    wr(`TMB_IDX_MODE, 8'h2C, OK);
    src.pulses(1, 1, 1);
    rdchk("cap0 pin", `TMB_IDX_CAP0_LO, 8'h01);
    rdchk("cap1 pin", `TMB_IDX_CAP1_LO, 8'h02);
    chk("irq0 on", n_irq0, 32'h1);
    chk("timer ff", {31'h0, ff}, 32'h1);
    $display("test run control done");
    close_out();
  end

endmodule
